// ---- dv/ebhp_eeprom_model.sv ----
`timescale 1ns/1ns
module ebhp_eeprom_model (
   input wire logic i_clk,
   input wire logic i_absent,
   input wire logic i_slow,
   input wire logic i_rd_start,
   input wire logic [15:0] i_rd_addr,
   input wire logic [15:0] i_rd_len,
   input wire logic i_wr_start,
   input wire logic [15:0] i_wr_addr,
   input wire logic [7:0] i_wr_byte,
   output logic o_rd_valid,
   output logic [7:0] o_rd_byte,
   output logic o_rd_done,
   output logic o_nack,
   output logic o_wr_done
);
   // ------------------------------------------------------------
   // Storage and idle levels
   // ------------------------------------------------------------
   logic [7:0] mem [0:255];
   logic [15:0] addr_r;
   logic [15:0] len_r;
   initial begin
      o_rd_valid = 1'b0;
      o_rd_byte = 8'hA5;
      o_rd_done = 1'b0;
      o_nack = 1'b0;
      o_wr_done = 1'b0;
   end
   // ------------------------------------------------------------
   // Read bursts: linear from the requested address
   // ------------------------------------------------------------
   always begin
      @(posedge i_clk);
      if (i_rd_start === 1'b1) begin
         addr_r = i_rd_addr;
         len_r = i_rd_len;
         @(negedge i_clk);
         if (i_absent) begin
            o_nack = 1'b1;
            @(negedge i_clk);
            o_nack = 1'b0;
         end else begin
            for (int i = 0; i < len_r; i++) begin
               if (i_slow && i > 0) begin
                  o_rd_valid = 1'b0;
                  o_rd_byte = ~o_rd_byte;
                  repeat (3) @(negedge i_clk);
               end
               o_rd_valid = 1'b1;
               o_rd_byte = mem[8'(addr_r + 16'(i))];
               @(negedge i_clk);
            end
            // Released data line flips so a stale byte never looks valid
            o_rd_valid = 1'b0;
            o_rd_byte = ~o_rd_byte;
            o_rd_done = 1'b1;
            @(negedge i_clk);
            o_rd_done = 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // Single-byte writes with a fixed busy time
   // ------------------------------------------------------------
   always begin
      @(posedge i_clk);
      if (i_wr_start === 1'b1) begin
         mem[i_wr_addr[7:0]] = i_wr_byte;
         repeat (4) @(negedge i_clk);
         o_wr_done = 1'b1;
         @(negedge i_clk);
         o_wr_done = 1'b0;
      end
   end
endmodule

// ---- dv/eeprom_boot_header_parser_bench.sv ----
`timescale 1ns/1ns
module eeprom_boot_header_parser_bench;
   import ebhp_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_dl_begin = 1'b0;
   logic i_dl_end = 1'b0;
   logic absent = 1'b0;
   logic slow = 1'b0;
   logic i_rd_valid, i_rd_done, i_nack, i_wr_done;
   logic [7:0] i_rd_byte;
   logic o_rd_start, o_wr_start, o_fast_i2c, o_mem_we, o_run, o_host_dl, o_bad_eeprom, o_dev_hdr, o_dl_marked;
   logic o_cpu_clk_24m, o_hdr_overwrite, o_self_pwr, o_bus_pwr, o_has_strings;
   logic [15:0] o_rd_addr, o_rd_len, o_wr_addr, o_wr_len, o_mem_addr, o_vendor_id, o_product_id;
   logic [7:0] o_wr_byte, o_mem_data, o_max_current, o_item_revision_byte, o_code_revision_byte;
   logic [6:0] o_i2c_dev_addr;
   logic [7:0] seed = 8'h14;
   int fails = 0;
   int n_tests = 0;
   logic [31:0] rd_q[$];
   logic [31:0] mem_q[$];
   logic [31:0] wr_q[$];
   always #5 i_core_clk = ~i_core_clk;
   ebhp_loader uut (.i_core_clk, .i_rst_b, .i_rd_valid, .i_rd_byte, .i_rd_done, .i_nack, .i_wr_done,
      .i_dl_begin, .i_dl_end, .o_rd_start, .o_rd_addr, .o_rd_len, .o_wr_start, .o_wr_addr, .o_wr_len,
      .o_wr_byte, .o_i2c_dev_addr, .o_fast_i2c, .o_mem_we, .o_mem_addr, .o_mem_data, .o_run, .o_host_dl,
      .o_bad_eeprom, .o_dev_hdr, .o_dl_marked, .o_cpu_clk_24m, .o_hdr_overwrite, .o_self_pwr, .o_bus_pwr,
      .o_has_strings, .o_max_current, .o_vendor_id, .o_product_id, .o_item_revision_byte,
      .o_code_revision_byte);
   ebhp_eeprom_model eep (.i_clk(i_core_clk), .i_absent(absent), .i_slow(slow), .i_rd_start(o_rd_start),
      .i_rd_addr(o_rd_addr), .i_rd_len(o_rd_len), .i_wr_start(o_wr_start), .i_wr_addr(o_wr_addr),
      .i_wr_byte(o_wr_byte), .o_rd_valid(i_rd_valid), .o_rd_byte(i_rd_byte), .o_rd_done(i_rd_done),
      .o_nack(i_nack), .o_wr_done(i_wr_done));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task final_report();
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task dl(input bit fin);
      @(negedge i_core_clk);
      if (fin) i_dl_end = 1'b1;
      else i_dl_begin = 1'b1;
      @(negedge i_core_clk);
      i_dl_begin = 1'b0;
      i_dl_end = 1'b0;
      repeat (10) @(negedge i_core_clk);
   endtask
   // ------------------------------------------------------------
   // Output watcher: each event takes the oldest expectation
   // ------------------------------------------------------------
   always @(posedge i_core_clk) begin
      if (o_rd_start === 1'b1) cmp("rd_req", rd_q.size() ? rd_q.pop_front() : 'x, {o_rd_addr, o_rd_len});
      if (o_mem_we === 1'b1) cmp("code_wr", mem_q.size() ? mem_q.pop_front() : 'x, {8'h00, o_mem_addr, o_mem_data});
      if (o_wr_start === 1'b1) cmp("kind_wr", wr_q.size() ? wr_q.pop_front() : 'x, {o_wr_addr, o_wr_len[7:0], o_wr_byte});
   end
   // ------------------------------------------------------------
   // One boot: build image, reset, check the outcome
   // ------------------------------------------------------------
   task run_case(input logic [7:0] kind, battr, dattr, rpage, input int ilen, nstr, input bit bsum, bsig, nk, slw);
      logic [7:0] sum;
      int len, rem, ch, a, i;
      bit valid, app, dev;
      len = 18 + nstr;
      for (a = 4; a < len + ilen; a++) eep.mem[a] = rnd();
      eep.mem[1] = 8'(len);
      eep.mem[2] = bsig ? 8'h35 : 8'h34;
      eep.mem[3] = 8'h12;
      eep.mem[10] = battr;
      eep.mem[12] = dattr;
      eep.mem[14] = kind;
      eep.mem[15] = rpage;
      eep.mem[16] = ilen[7:0];
      eep.mem[17] = ilen[15:8];
      sum = 8'h00;
      for (a = 1; a < len; a++) sum = sum + eep.mem[a];
      eep.mem[0] = sum + 8'(bsum);
      valid = !bsum && !bsig && !nk && (kind == 8'h01 || (kind == 8'h02 && ilen == 0));
      app = valid && kind == 8'h01;
      dev = valid && kind == 8'h02;
      rd_q.push_back({16'h0000, 16'h0012});
      if (!nk && len > 18) rd_q.push_back({16'h0012, 16'(len - 18)});
      if (app) begin
         rem = ilen;
         a = len;
         while (rem > 0) begin
            ch = (rpage == 0 || rpage > rem) ? rem : rpage;
            rd_q.push_back({16'(a), 16'(ch)});
            a += ch;
            rem -= ch;
         end
         for (i = 0; i < ilen; i++) mem_q.push_back({8'h00, 16'(i), eep.mem[len + i]});
      end
      @(negedge i_core_clk);
      absent = nk;
      slow = slw;
      i_rst_b = 1'b0;
      repeat (20) @(negedge i_core_clk);
      i_rst_b = 1'b1;
      for (a = 0; a < 3000 && o_run !== 1'b1 && o_host_dl !== 1'b1; a++) @(negedge i_core_clk);
      repeat (4) @(negedge i_core_clk);
      cmp("path", {app, !app, !valid, dev}, {o_run, o_host_dl, o_bad_eeprom, o_dev_hdr});
      cmp("ids", valid ? {eep.mem[5], eep.mem[4], eep.mem[7], eep.mem[6]} : 0, {o_vendor_id, o_product_id});
      cmp("info", valid ? {eep.mem[11], eep.mem[8], eep.mem[9]} : 0, {o_max_current, o_item_revision_byte, o_code_revision_byte});
      cmp("attr", valid ? {battr[0], battr[2], battr[3], dattr[0], dattr[1], dattr[3]} : 0,
         {o_has_strings, o_self_pwr, o_bus_pwr, o_cpu_clk_24m, o_hdr_overwrite, o_fast_i2c});
      cmp("dev_addr", 7'h50, o_i2c_dev_addr);
      if (!app) begin
         if (dev) wr_q.push_back({16'h000E, 8'h01, 8'h03});
         dl(1'b0);
         cmp("marked", dev, o_dl_marked);
         if (dev) wr_q.push_back({16'h000E, 8'h01, kind});
         dl(1'b1);
         cmp("unmarked", 0, o_dl_marked);
         if (dev) cmp("kind_byte", kind, eep.mem[14]);
      end
      cmp("left", 0, rd_q.size() + mem_q.size() + wr_q.size());
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      run_case(8'h01, 8'h0D, 8'h0B, 8'h04, 10, 8, 0, 0, 0, 0);
      run_case(8'h01, 8'h00, 8'h00, 8'h00, 5, 0, 0, 0, 0, 1);
      run_case(8'h01, 8'h04, 8'h08, 8'h03, 0, 0, 0, 0, 0, 0);
      run_case(8'h02, 8'h09, 8'h02, 8'h00, 0, 6, 0, 0, 0, 1);
      run_case(8'h01, 8'h00, 8'h08, 8'h02, 3, 0, 1, 0, 0, 0);
      run_case(8'h02, 8'h01, 8'h00, 8'h00, 0, 6, 0, 1, 0, 0);
      run_case(8'h00, 8'h00, 8'h01, 8'h00, 0, 0, 0, 0, 0, 0);
      run_case(8'h03, 8'h00, 8'h01, 8'h00, 4, 0, 0, 0, 0, 0);
      run_case(8'h01, 8'h00, 8'h00, 8'h00, 2, 0, 0, 0, 1, 0);
      final_report();
   end
   initial begin
      repeat (50000) @(posedge i_core_clk);
      fails++;
      final_report();
   end
endmodule

// ---- hdl/ebhp_loader.sv ----
`timescale 1ns/1ns
module ebhp_loader (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_rd_valid,
   input wire logic [7:0] i_rd_byte,
   input wire logic i_rd_done,
   input wire logic i_nack,
   input wire logic i_wr_done,
   input wire logic i_dl_begin,
   input wire logic i_dl_end,
   output logic o_rd_start,
   output logic [15:0] o_rd_addr,
   output logic [15:0] o_rd_len,
   output logic o_wr_start,
   output logic [15:0] o_wr_addr,
   output logic [15:0] o_wr_len,
   output logic [7:0] o_wr_byte,
   output logic [6:0] o_i2c_dev_addr,
   output logic o_fast_i2c,
   output logic o_mem_we,
   output logic [15:0] o_mem_addr,
   output logic [7:0] o_mem_data,
   output logic o_run,
   output logic o_host_dl,
   output logic o_bad_eeprom,
   output logic o_dev_hdr,
   output logic o_dl_marked,
   output logic o_cpu_clk_24m,
   output logic o_hdr_overwrite,
   output logic o_self_pwr,
   output logic o_bus_pwr,
   output logic o_has_strings,
   output logic [7:0] o_max_current,
   output logic [15:0] o_vendor_id,
   output logic [15:0] o_product_id,
   output logic [7:0] o_item_revision_byte,
   output logic [7:0] o_code_revision_byte
);
   import ebhp_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_b;
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Header store and field views
   // ------------------------------------------------------------
   ebhp_state_e state_r;
   logic [7:0] hdr_r [HDR_FIXED];
   logic [15:0] cnt_r;
   logic [7:0] sum_r;
   logic [15:0] remain_r;
   logic [15:0] ee_addr_r;
   logic [7:0] saved_kind_r;
   logic valid_r;
   logic [7:0] hdr_length;
   logic [7:0] bus_attr_byte;
   logic [7:0] dev_attr_byte;
   logic [7:0] write_burst_len;
   logic [7:0] read_burst_len;
   logic [7:0] image_kind;
   logic [15:0] image_length;
   logic [15:0] sig_word;
   logic [15:0] chunk;
   logic strings_ok;
   logic hdr_ok;

   assign hdr_length = hdr_r[OFF_LEN];
   assign bus_attr_byte = hdr_r[OFF_BATTR];
   assign dev_attr_byte = hdr_r[OFF_DATTR];
   assign write_burst_len = hdr_r[OFF_WPAGE];
   assign read_burst_len = hdr_r[OFF_RPAGE];
   assign image_kind = hdr_r[OFF_KIND];
   assign image_length = {hdr_r[OFF_ILEN + 1], hdr_r[OFF_ILEN]};
   assign sig_word = {hdr_r[OFF_SIG + 1], hdr_r[OFF_SIG]};

   // Strings come as a set; a lone language string cannot be told apart
   assign strings_ok = bus_attr_byte[BA_STRINGS] ? ({8'h00, hdr_length} > HDR_FIXED_W + LANG_LEN_W)
                                                 : ({8'h00, hdr_length} == HDR_FIXED_W);
   assign hdr_ok = (sum_r == hdr_r[OFF_SUM])
                 && (sig_word == SIG_VALUE)
                 && strings_ok
                 && ((image_kind == KIND_APP)
                     || ((image_kind == KIND_DEV) && (image_length == 16'h0000)));

   // Payload chunk: zero read page means the whole remainder at once
   assign chunk = ((read_burst_len == 8'h00) || ({8'h00, read_burst_len} >= remain_r))
                  ? remain_r : {8'h00, read_burst_len};

   generate
      for (genvar g = 0; g < HDR_FIXED; g++) begin : g_hdr
         always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               hdr_r[g] <= 8'h00;
            end else if ((state_r == ST_HDR_RD) && i_rd_valid && (cnt_r == 16'(g))) begin
               hdr_r[g] <= i_rd_byte;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Byte counter and checksum
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cnt_r <= 16'h0000;
         sum_r <= 8'h00;
      end else if (((state_r == ST_HDR_RD) || (state_r == ST_STR_RD)) && i_rd_valid) begin
         cnt_r <= cnt_r + 16'h0001;
         if (cnt_r != 16'(OFF_SUM)) begin
            sum_r <= sum_r + i_rd_byte;
         end
      end
   end

   // ------------------------------------------------------------
   // Boot sequencer
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_r <= ST_HDR_REQ;
         o_rd_start <= 1'b0;
         o_rd_addr <= 16'h0000;
         o_rd_len <= 16'h0000;
         remain_r <= 16'h0000;
         ee_addr_r <= 16'h0000;
         valid_r <= 1'b0;
         o_run <= 1'b0;
         o_host_dl <= 1'b0;
         o_bad_eeprom <= 1'b0;
         o_dev_hdr <= 1'b0;
      end else begin
         o_rd_start <= 1'b0;
         case (state_r)
            ST_HDR_REQ: begin
               o_rd_start <= 1'b1;
               o_rd_addr <= HDR_BASE;
               o_rd_len <= HDR_FIXED_W;
               state_r <= ST_HDR_RD;
            end
            ST_HDR_RD: begin
               if (i_nack) begin
                  state_r <= ST_HOST;
                  o_host_dl <= 1'b1;
                  o_bad_eeprom <= 1'b1;
               end else if (i_rd_done) begin
                  if ({8'h00, hdr_length} > HDR_FIXED_W) begin
                     state_r <= ST_STR_REQ;
                  end else begin
                     state_r <= ST_CHECK;
                  end
               end
            end
            ST_STR_REQ: begin
               o_rd_start <= 1'b1;
               o_rd_addr <= HDR_FIXED_W;
               o_rd_len <= {8'h00, hdr_length} - HDR_FIXED_W;
               state_r <= ST_STR_RD;
            end
            ST_STR_RD: begin
               if (i_nack) begin
                  state_r <= ST_HOST;
                  o_host_dl <= 1'b1;
                  o_bad_eeprom <= 1'b1;
               end else if (i_rd_done) begin
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               valid_r <= hdr_ok;
               if (hdr_ok && (image_kind == KIND_APP)) begin
                  remain_r <= image_length;
                  ee_addr_r <= HDR_BASE + {8'h00, hdr_length};
                  state_r <= ST_LOAD_REQ;
               end else begin
                  state_r <= ST_HOST;
                  o_host_dl <= 1'b1;
                  o_bad_eeprom <= !hdr_ok;
                  o_dev_hdr <= hdr_ok;
               end
            end
            ST_LOAD_REQ: begin
               if (remain_r == 16'h0000) begin
                  state_r <= ST_RUN;
               end else begin
                  o_rd_start <= 1'b1;
                  o_rd_addr <= ee_addr_r;
                  o_rd_len <= chunk;
                  remain_r <= remain_r - chunk;
                  ee_addr_r <= ee_addr_r + chunk;
                  state_r <= ST_LOAD_RD;
               end
            end
            ST_LOAD_RD: begin
               if (i_nack) begin
                  state_r <= ST_HOST;
                  o_host_dl <= 1'b1;
                  o_bad_eeprom <= 1'b1;
               end else if (i_rd_done) begin
                  state_r <= ST_LOAD_REQ;
               end
            end
            ST_RUN: begin
               o_run <= 1'b1;
            end
            ST_HOST: begin
               if (i_dl_begin && !o_dl_marked && !o_bad_eeprom) begin
                  state_r <= ST_MARK_WAIT;
               end else if (i_dl_end && o_dl_marked) begin
                  state_r <= ST_MARK_WAIT;
               end
            end
            ST_MARK_WAIT: begin
               if (i_wr_done) begin
                  state_r <= ST_HOST;
               end
            end
            default: begin
               state_r <= ST_HDR_REQ;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Code memory writes during load
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         o_mem_we <= 1'b0;
         o_mem_addr <= CODE_BASE;
         o_mem_data <= 8'h00;
      end else begin
         o_mem_we <= (state_r == ST_LOAD_RD) && i_rd_valid;
         o_mem_data <= i_rd_byte;
         if (o_mem_we) begin
            o_mem_addr <= o_mem_addr + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Update marker on the kind byte
   // ------------------------------------------------------------
   // A single-byte write always fits any nonzero write page
   always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         o_wr_start <= 1'b0;
         o_wr_addr <= 16'h0000;
         o_wr_len <= 16'h0000;
         o_wr_byte <= 8'h00;
         o_dl_marked <= 1'b0;
         saved_kind_r <= 8'h00;
      end else begin
         o_wr_start <= 1'b0;
         if ((state_r == ST_HOST) && i_dl_begin && !o_dl_marked && !o_bad_eeprom) begin
            saved_kind_r <= image_kind;
            o_wr_start <= 1'b1;
            o_wr_addr <= HDR_BASE + 16'(OFF_KIND);
            o_wr_len <= 16'h0001;
            o_wr_byte <= KIND_UPD;
            o_dl_marked <= 1'b1;
         end else if ((state_r == ST_HOST) && i_dl_end && o_dl_marked) begin
            o_wr_start <= 1'b1;
            o_wr_addr <= HDR_BASE + 16'(OFF_KIND);
            o_wr_len <= 16'h0001;
            o_wr_byte <= saved_kind_r;
            o_dl_marked <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Reported header fields
   // ------------------------------------------------------------
   // Header fields read as zero until the header is proven good; the device address always reads I2C_DEV_ADDR
   always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         o_i2c_dev_addr <= I2C_DEV_ADDR;
         o_fast_i2c <= 1'b0;
         o_cpu_clk_24m <= 1'b0;
         o_hdr_overwrite <= 1'b0;
         o_self_pwr <= 1'b0;
         o_bus_pwr <= 1'b0;
         o_has_strings <= 1'b0;
         o_max_current <= 8'h00;
         o_vendor_id <= 16'h0000;
         o_product_id <= 16'h0000;
         o_item_revision_byte <= 8'h00;
         o_code_revision_byte <= 8'h00;
      end else begin
         o_i2c_dev_addr <= I2C_DEV_ADDR;
         o_fast_i2c <= valid_r && dev_attr_byte[DA_FAST];
         o_cpu_clk_24m <= valid_r && dev_attr_byte[DA_CLK24];
         o_hdr_overwrite <= valid_r && dev_attr_byte[DA_HDR_WR];
         o_self_pwr <= valid_r && bus_attr_byte[BA_SELF_PWR];
         o_bus_pwr <= valid_r && bus_attr_byte[BA_BUS_PWR];
         o_has_strings <= valid_r && bus_attr_byte[BA_STRINGS];
         o_max_current <= valid_r ? hdr_r[OFF_MAXI] : 8'h00;
         o_vendor_id <= valid_r ? {hdr_r[OFF_VID + 1], hdr_r[OFF_VID]} : 16'h0000;
         o_product_id <= valid_r ? {hdr_r[OFF_PID + 1], hdr_r[OFF_PID]} : 16'h0000;
         o_item_revision_byte <= valid_r ? hdr_r[OFF_PREV] : 8'h00;
         o_code_revision_byte <= valid_r ? hdr_r[OFF_CREV] : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_sync_b);

   sequence s_check_app;
      state_r == ST_CHECK && hdr_ok && image_kind == KIND_APP;
   endsequence
   sequence s_check_bad;
      state_r == ST_CHECK && !hdr_ok;
   endsequence

   chk_app_loads: assert property (s_check_app |=> state_r == ST_LOAD_REQ)
      else $error("valid application header did not start loading");
   chk_bad_no_run: assert property (s_check_bad |=> (o_host_dl && o_bad_eeprom && !o_run) [*3])
      else $error("bad header did not take the host path");
   chk_dev_path: assert property (state_r == ST_CHECK && hdr_ok && image_kind == KIND_DEV
                                   |=> o_dev_hdr && !o_bad_eeprom ##2 !o_run)
      else $error("device header did not take the reporting path");
   chk_hdr_addr: assert property ($rose(o_rd_start) && $past(state_r) == ST_HDR_REQ
                                   |-> o_rd_addr == HDR_BASE && o_rd_len == HDR_FIXED_W)
      else $error("header read not at address zero");
   chk_sum_gate: assert property (state_r == ST_CHECK && sum_r != hdr_r[OFF_SUM] |=> !valid_r)
      else $error("checksum mismatch accepted");
   chk_kind_valid: assert property (o_run |-> valid_r && image_kind == KIND_APP)
      else $error("code run with a wrong image kind");
   chk_fast_gate: assert property (o_fast_i2c |-> $past(dev_attr_byte[DA_FAST]) && $past(valid_r))
      else $error("fast bus used without permission");
   chk_clk_select: assert property (o_cpu_clk_24m |-> $past(dev_attr_byte[DA_CLK24]))
      else $error("processor clock select mismatch");
   chk_rd_burst: assert property (o_rd_start && $past(state_r) == ST_LOAD_REQ && read_burst_len != 8'h00
                                   |-> o_rd_len <= {8'h00, read_burst_len})
      else $error("payload read longer than read page");
   chk_wr_burst: assert property (o_wr_start && write_burst_len != 8'h00
                                   |-> o_wr_len <= {8'h00, write_burst_len})
      else $error("write burst longer than write page");
   chk_mark_value: assert property ($rose(o_dl_marked) |-> o_wr_start && o_wr_byte == KIND_UPD
                                     && o_wr_addr == 16'(OFF_KIND))
      else $error("update marker not written");
   chk_dev_addr: assert property (o_i2c_dev_addr == 7'h50)
      else $error("wrong EEPROM device address");
endmodule

// ---- hdl/ebhp_pkg.sv ----
package ebhp_pkg;
   // ------------------------------------------------------------
   // Header byte offsets
   // ------------------------------------------------------------
   localparam int OFF_SUM = 0;
   localparam int OFF_LEN = 1;
   localparam int OFF_SIG = 2;
   localparam int OFF_VID = 4;
   localparam int OFF_PID = 6;
   localparam int OFF_PREV = 8;
   localparam int OFF_CREV = 9;
   localparam int OFF_BATTR = 10;
   localparam int OFF_MAXI = 11;
   localparam int OFF_DATTR = 12;
   localparam int OFF_WPAGE = 13;
   localparam int OFF_KIND = 14;
   localparam int OFF_RPAGE = 15;
   localparam int OFF_ILEN = 16;
   localparam int HDR_FIXED = 18;
   localparam int LANG_LEN = 4;
   // ------------------------------------------------------------
   // Field bits and codes
   // ------------------------------------------------------------
   localparam int BA_STRINGS = 0;
   localparam int BA_SELF_PWR = 2;
   localparam int BA_BUS_PWR = 3;
   localparam int DA_CLK24 = 0;
   localparam int DA_HDR_WR = 1;
   localparam int DA_FAST = 3;
   localparam logic [15:0] SIG_VALUE = 16'h1234;
   localparam logic [7:0] KIND_APP = 8'h01;
   localparam logic [7:0] KIND_DEV = 8'h02;
   localparam logic [7:0] KIND_UPD = 8'h03;
   localparam logic [15:0] HDR_BASE = 16'h0000;
   localparam logic [15:0] CODE_BASE = 16'h0000;
   localparam logic [15:0] HDR_FIXED_W = 16'h0012;
   localparam logic [15:0] LANG_LEN_W = 16'h0004;
   localparam logic [3:0] I2C_CTRL_CODE = 4'hA;
   localparam logic [2:0] I2C_CHIP_SEL = 3'h0;
   localparam logic [6:0] I2C_DEV_ADDR = {I2C_CTRL_CODE, I2C_CHIP_SEL};
   typedef enum {
      ST_HDR_REQ, ST_HDR_RD, ST_STR_REQ, ST_STR_RD, ST_CHECK,
      ST_LOAD_REQ, ST_LOAD_RD, ST_RUN, ST_HOST, ST_MARK_WAIT
   } ebhp_state_e;
endpackage
